// ---- pms_ctrl.v ----
// Notes on behaviour
// [RULE1] 26-bit modes 00000..00011; fast interrupt mode banks registers 8 to 14.
// [RULE2] 32-bit modes 10000..11011; privileged ones bank r13, r14 and saved word.
// [RULE3] Mode 11111 is privileged system mode, user registers, no saved word.
// [RULE4] Without 26-bit support mode bit 4 reads one and ignores writes.
// [RULE5] Program and data width selects live in control register 1.
// [RULE6] Program width select on: all exceptions go to 32-bit modes.
// [RULE7] 32-bit config: mode moves via status write or compare variants.
// [RULE8] Exception from 26-bit mode: link gets pc 25..2, saved gets status.
// [RULE9] Software never sets program width without data width.
// [RULE10] Program width off: stay 26-bit, ignore mode bits 4..2, aborts to svc.
// [RULE11] 26-bit configuration limits the program counter to 64 Megabytes.
// [RULE12] 26-bit data: address exception when any top six address bits set.
// [RULE13] Data width on in 26-bit config: full 32-bit addresses, no check.
// [RULE14] 26-bit mode in 32-bit config: data write to 0x0..0x1f aborts.
// [RULE15] Whether data reads of hard vectors abort is a fixed choice.
// [RULE16] Compact state: r15 bit 0 reads zero and is ignored on write.
// [RULE17] State bit 5 selects step of four or two.
// [RULE18] Branch exchange jumps and takes state from target bit 0.
// [RULE19] Restoring status from saved word enters compact state if bit set.
// [RULE20] Software never alters the state bit by a direct status write.
// [RULE21] Exceptions enter full-width state, keeping state bit in saved word; from a 26-bit mode in 32-bit config the saved copy has bit 5 clear.
// [RULE22] Compact-state link offsets: undef/swi +2, fetch +4, data +8, irq +4.
// [RULE23] Address exception: svc link addr+4, mode 00011, irq off, jump 0x14.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "pms_defs.vh"
module pms_ctrl (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Core events
  input  wire        exc_req,
  input  wire [2:0]  exc_kind,
  input  wire [31:0] exc_addr,
  input  wire        sw_req,
  input  wire        sw_kind,
  input  wire [31:0] sw_data,
  input  wire        restore_req,
  input  wire [31:0] restore_pc,
  input  wire        bx_req,
  input  wire [31:0] bx_target,
  input  wire        pc_we,
  input  wire [31:0] pc_wdata,
  input  wire        pc_step,
  // Data access check
  input  wire        dacc_valid,
  input  wire        dacc_write,
  input  wire [31:0] dacc_addr,
  input  wire [31:0] dacc_insn_addr,
  // State outputs
  output reg  [31:0] status_word,
  output reg  [31:0] saved_word,
  output reg         has_saved,
  output reg  [31:0] pc,
  output reg  [31:0] r15_value,
  output reg         compact,
  output reg         hi_bank_fiq,
  output reg  [2:0]  sp_lr_bank,
  output reg         program_space_width_select,
  output reg         data_space_width_select,
  // Exception results
  output reg         link_we,
  output reg  [2:0]  link_bank,
  output reg  [31:0] link_data,
  output reg         vec_valid,
  output reg  [31:0] vec_addr,
  output reg         addr_exc,
  output reg         vec_abort,
  output reg  [31:0] daddr_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] bank_of;
    input [4:0] m;
    begin
      case (m[3:0])
        4'h1:    bank_of = 3'h1;
        4'h2:    bank_of = 3'h2;
        4'h3:    bank_of = 3'h3;
        4'h7:    bank_of = 3'h4;
        4'hB:    bank_of = 3'h5;
        default: bank_of = 3'h0; // User and system share, no saved word [RULE3]
      endcase
    end
  endfunction

  function mode_ok;
    input [4:0] m;
    input       p32;
    begin
      case (m)
        `PMS_M_USR26, `PMS_M_FIQ26,
        `PMS_M_IRQ26, `PMS_M_SVC26: mode_ok = `PMS_HAS_26BIT; // [RULE1]
        `PMS_M_USR32, `PMS_M_FIQ32, `PMS_M_IRQ32,
        `PMS_M_SVC32, `PMS_M_ABT32, `PMS_M_UND32: mode_ok = p32; // [RULE2]
        `PMS_M_SYS32: mode_ok = p32 & `PMS_HAS_SYS; // [RULE3]
        default: mode_ok = 1'b0;
      endcase
    end
  endfunction

  function [4:0] exc_mode;
    input [2:0] k;
    input       p32;
    begin
      case (k)
        `PMS_X_FIQ:   exc_mode = p32 ? `PMS_M_FIQ32 : `PMS_M_FIQ26;
        `PMS_X_IRQ:   exc_mode = p32 ? `PMS_M_IRQ32 : `PMS_M_IRQ26;
        `PMS_X_UNDEF: exc_mode = p32 ? `PMS_M_UND32 : `PMS_M_SVC26; // [RULE6] [RULE10]
        `PMS_X_PABT,
        `PMS_X_DABT:  exc_mode = p32 ? `PMS_M_ABT32 : `PMS_M_SVC26; // [RULE6] [RULE10]
        // Address faults arise only in 26-bit config, so this is svc26 in practice
        `PMS_X_ADDR:  exc_mode = p32 ? `PMS_M_SVC32 : `PMS_M_SVC26; // [RULE6] [RULE23]
        default:      exc_mode = p32 ? `PMS_M_SVC32 : `PMS_M_SVC26; // [RULE6]
      endcase
    end
  endfunction

  // ----------------------------------------
  // Bank of saved words, index = bank - 1
  // ----------------------------------------
  // Reset value of the width selects, split per bit
  localparam [1:0] CTRL_RST = `PMS_CTRL_RST;
  reg  [31:0] saved_mem [0:4];
  reg  [31:0] link_last;
  reg         ack;

  wire [2:0]  cur_bank = bank_of(status_word[4:0]);
  wire [31:0] cur_saved = (cur_bank == 3'h0) ? 32'h0 : saved_mem[cur_bank - 3'h1];
  wire        cur_t = status_word[`PMS_T_BIT];
  wire        priv = (status_word[4:0] != `PMS_M_USR26) && (status_word[4:0] != `PMS_M_USR32);

  // ----------------------------------------
  // Data address checks
  // ----------------------------------------
  // Address faults only exist in 26-bit data space [RULE12] [RULE13]
  wire addr_fault = dacc_valid & ~program_space_width_select & ~data_space_width_select & (|dacc_addr[31:26]); // [RULE12]
  wire in_vec = (dacc_addr <= `PMS_HARD_VEC_TOP);
  // Only flagged here; the core must still raise the data abort
  wire vec_fault = dacc_valid & program_space_width_select & ~status_word[`PMS_M4_BIT] & in_vec &
                   (dacc_write | `PMS_VEC_RD_ABORT); // [RULE14] [RULE15]

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  reg  [31:0] next_sw;
  reg  [31:0] next_pc;
  reg         next_sv_we;
  reg  [2:0]  next_sv_bank;
  reg  [31:0] next_sv_data;
  reg         next_lk_we;
  reg  [31:0] next_lk;
  reg         next_vec_valid;
  reg  [31:0] next_vec;
  reg  [2:0]  kind;
  reg  [31:0] xaddr;
  reg  [4:0]  m;
  reg         from26;

  always @* begin
    next_sw = status_word;
    next_pc = pc;
    next_sv_we = 1'b0;
    next_sv_bank = 3'h0;
    next_sv_data = 32'h0;
    next_lk_we = 1'b0;
    next_lk = 32'h0;
    next_vec_valid = 1'b0;
    next_vec = 32'h0;
    kind = exc_req ? exc_kind : `PMS_X_ADDR;
    xaddr = exc_req ? exc_addr : dacc_insn_addr;
    m = status_word[4:0];
    from26 = program_space_width_select & ~status_word[`PMS_M4_BIT];
    if (exc_req | addr_fault) begin
      m = exc_mode(kind, program_space_width_select);
      if (!`PMS_HAS_26BIT)
        m[4] = 1'b1; // [RULE4]
      case (kind)
        `PMS_X_UNDEF,
        `PMS_X_SWI:  next_lk = xaddr + (cur_t ? `PMS_PLUS2 : `PMS_PLUS4); // [RULE22]
        `PMS_X_DABT: next_lk = xaddr + `PMS_PLUS8; // [RULE22]
        `PMS_X_RESET: next_lk = 32'h0;
        default:     next_lk = xaddr + `PMS_PLUS4; // [RULE22] [RULE23]
      endcase
      // Only the pc field survives a 26-bit origin in 32-bit config
      if (from26)
        next_lk = next_lk & `PMS_PC26_MASK; // [RULE8]
      next_lk_we = (kind != `PMS_X_RESET);
      next_sv_we = (kind != `PMS_X_RESET) && (bank_of(m) != 3'h0);
      next_sv_bank = bank_of(m);
      next_sv_data = from26 ? {status_word[31:28], 20'h0, status_word[7:6], 4'h0, status_word[1:0]}
                            : status_word; // [RULE8] [RULE21]
      next_sw = {status_word[31:8], 1'b1,
                 (kind == `PMS_X_FIQ) | (kind == `PMS_X_RESET) | status_word[`PMS_F_BIT],
                 1'b0, m}; // [RULE21] [RULE23]
      next_vec_valid = 1'b1;
      next_vec = {27'h0, kind, 2'h0}; // [RULE23]
      next_pc = next_vec;
    end else if (restore_req) begin
      // User and system have no saved word, so only the pc moves
      if (cur_bank != 3'h0) begin
        m = program_space_width_select ? cur_saved[4:0] : {status_word[4:2], cur_saved[1:0]};
        if (!`PMS_HAS_26BIT)
          m[4] = 1'b1;
        next_sw = {cur_saved[31:5], mode_ok(m, program_space_width_select) ? m : status_word[4:0]}; // [RULE19]
      end
      next_pc = next_sw[`PMS_T_BIT] ? {restore_pc[31:1], 1'b0} : {restore_pc[31:2], 2'h0};
    end else if (sw_req) begin
      // Flags follow the write in every mode, user included, except compare variants in 32-bit modes
      next_sw[31:28] = sw_data[31:28];
      if (sw_kind == `PMS_SWK_PSR_WRITE_COMPARE) begin
        // Compare variants only move between 26-bit modes [RULE7]
        if (!status_word[`PMS_M4_BIT] && priv) begin
          next_sw[7:6] = sw_data[7:6];
          next_sw[1:0] = sw_data[1:0];
        end else if (status_word[`PMS_M4_BIT])
          next_sw[31:28] = status_word[31:28];
      end else if (priv) begin
        next_sw[7:6] = sw_data[7:6];
        m = program_space_width_select ? sw_data[4:0] : {status_word[4:2], sw_data[1:0]}; // [RULE7] [RULE10]
        if (!`PMS_HAS_26BIT)
          m[4] = 1'b1; // [RULE4]
        if (mode_ok(m, program_space_width_select))
          next_sw[4:0] = m;
      end
      // State bit is never taken from a direct write [RULE20]
      next_sw[`PMS_T_BIT] = status_word[`PMS_T_BIT];
    end else if (bx_req) begin
      next_sw[`PMS_T_BIT] = bx_target[0]; // [RULE18]
      next_pc = bx_target[0] ? {bx_target[31:1], 1'b0} : {bx_target[31:2], 2'h0};
    end else if (pc_we) begin
      // Low pc bits are dropped, never trapped
      next_pc = cur_t ? {pc_wdata[31:1], 1'b0} : {pc_wdata[31:2], 2'h0}; // [RULE16]
    end else if (pc_step) begin
      next_pc = pc + (cur_t ? `PMS_PLUS2 : `PMS_PLUS4); // [RULE17]
    end
    if (!program_space_width_select)
      next_pc = next_pc & `PMS_PC26_KEEP; // [RULE11]
  end

  // ----------------------------------------
  // Avalon slave, one wait state per access
  // ----------------------------------------
  // Trades a cycle per access for registered read data
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  reg [31:0] rd_mux;
  always @* begin
    case (avs_address & 8'hFC)
      `PMS_OFS_CTRL:   rd_mux = {30'h0, data_space_width_select, program_space_width_select}; // [RULE5]
      `PMS_OFS_STATUS: rd_mux = status_word;
      `PMS_OFS_SAVED:  rd_mux = saved_word;
      `PMS_OFS_LINK:   rd_mux = link_last;
      `PMS_OFS_PC:     rd_mux = pc;
      default:         rd_mux = 32'h0;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      program_space_width_select <= CTRL_RST[`PMS_CTRL_PROG];
      data_space_width_select <= CTRL_RST[`PMS_CTRL_DATA];
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read & ~ack)
        avs_readdata <= rd_mux;
      // Write lands on the edge at which the master sees waitrequest low
      if (avs_write & ack && (avs_address & 8'hFC) == `PMS_OFS_CTRL && avs_byteenable[0]) begin
        program_space_width_select <= avs_writedata[`PMS_CTRL_PROG]; // [RULE5]
        data_space_width_select <= avs_writedata[`PMS_CTRL_DATA]; // [RULE5]
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  integer i;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_word <= `PMS_SW_RST;
      pc <= 32'h0;
      r15_value <= `PMS_PLUS8;
      compact <= 1'b0;
      hi_bank_fiq <= 1'b0;
      sp_lr_bank <= 3'h3;
      saved_word <= 32'h0;
      has_saved <= 1'b1;
      link_we <= 1'b0;
      link_bank <= 3'h0;
      link_data <= 32'h0;
      link_last <= 32'h0;
      vec_valid <= 1'b0;
      vec_addr <= 32'h0;
      addr_exc <= 1'b0;
      vec_abort <= 1'b0;
      daddr_out <= 32'h0;
      for (i = 0; i < 5; i = i + 1)
        saved_mem[i] <= 32'h0;
    end else begin
      status_word <= next_sw;
      pc <= next_pc;
      // Compact reads show bit 0 clear at pc + 4 [RULE16]
      r15_value <= next_sw[`PMS_T_BIT] ? ({next_pc[31:1], 1'b0} + `PMS_PLUS4) : (next_pc + `PMS_PLUS8);
      compact <= next_sw[`PMS_T_BIT]; // [RULE17]
      hi_bank_fiq <= (bank_of(next_sw[4:0]) == 3'h1); // [RULE1]
      sp_lr_bank <= bank_of(next_sw[4:0]); // [RULE2]
      has_saved <= (bank_of(next_sw[4:0]) != 3'h0); // [RULE3]
      // Saved word bypasses the bank so a new entry shows at once
      saved_word <= (next_sv_we && next_sv_bank == bank_of(next_sw[4:0])) ? next_sv_data :
                    ((bank_of(next_sw[4:0]) == 3'h0) ? 32'h0 : saved_mem[bank_of(next_sw[4:0]) - 3'h1]);
      if (next_sv_we)
        saved_mem[next_sv_bank - 3'h1] <= next_sv_data; // [RULE2] [RULE21]
      link_we <= next_lk_we;
      link_bank <= bank_of(next_sw[4:0]);
      // Link value is kept across reset entries
      if (next_lk_we) begin
        link_data <= next_lk;
        link_last <= next_lk;
      end
      vec_valid <= next_vec_valid;
      vec_addr <= next_vec;
      // A fault beside a core exception is lost; the exception wins
      addr_exc <= addr_fault & ~exc_req; // [RULE12]
      vec_abort <= vec_fault; // [RULE14]
      if (dacc_valid)
        daddr_out <= dacc_addr; // [RULE13]
    end
  end

endmodule // pms_ctrl

// ---- pms_ctrl_chk_asserts.sv ----
`timescale 1ns/100ps
module pms_ctrl_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Core events
  input wire        exc_req,
  input wire        bx_req,
  input wire        pc_step,
  input wire        pc_we,
  input wire        sw_req,
  input wire        restore_req,
  input wire        dacc_valid,
  input wire        dacc_write,
  input wire [2:0]  exc_kind,
  input wire [31:0] exc_addr,
  input wire [31:0] bx_target,
  input wire [31:0] dacc_addr,
  input wire [31:0] dacc_insn_addr,
  // State and results
  input wire [31:0] status_word,
  input wire [31:0] saved_word,
  input wire [31:0] pc,
  input wire [31:0] r15_value,
  input wire [31:0] link_data,
  input wire        compact,
  input wire        program_space_width_select,
  input wire        data_space_width_select,
  input wire        addr_exc,
  input wire        vec_abort
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // State and exception entry
  // ----------------------------------------
  state_bit_track_a: assert property (compact == status_word[5])
    else $error("compact differs from state bit");
  pc_step_size_a: assert property (pc_step && !(exc_req|dacc_valid|restore_req|sw_req|bx_req|pc_we)
    |=> pc == $past(pc) + ($past(compact) ? 32'h2 : 32'h4)) else $error("pc step size wrong");
  r15_view_a: assert property ($stable(pc) && $stable(compact) |->
    r15_value == (compact ? {pc[31:1], 1'b0} + 32'h4 : pc + 32'h8)) else $error("r15 view wrong");
  bx_state_a: assert property (bx_req && program_space_width_select && !(exc_req|dacc_valid|restore_req|sw_req) |=>
    compact == $past(bx_target[0]) && pc[31:2] == $past(bx_target[31:2])) else $error("bx target");
  exc_full_a: assert property (exc_req |=> !compact && status_word[4] == $past(program_space_width_select))
    else $error("exception entry state wrong");
  saved_state_a: assert property (exc_req && exc_kind != 3'h0 && compact |=> saved_word[5])
    else $error("state bit not saved");
  link_compact_a: assert property (exc_req && compact && program_space_width_select && status_word[4] &&
    (exc_kind == 3'h1 || exc_kind == 3'h2) |=> link_data == $past(exc_addr) + 32'h2)
    else $error("compact link offset wrong");
  pc26_limit_a: assert property (!program_space_width_select && !$past(program_space_width_select) |-> pc[31:26] == 6'h00)
    else $error("pc beyond 26-bit space");
  // ----------------------------------------
  // Data address checks
  // ----------------------------------------
  // The abort is raised even beside a core exception; the core decides
  vec_abort_cause_a: assert property (vec_abort |-> $past(dacc_valid) && $past(dacc_write) &&
    $past(program_space_width_select) && !$past(status_word[4]) && $past(dacc_addr) <= 32'h1F)
    else $error("vector abort without cause");
  vec_abort_fire_a: assert property (dacc_valid && dacc_write && program_space_width_select && !status_word[4] &&
    dacc_addr <= 32'h1F |=> vec_abort) else $error("vector write not aborted");
  vec_read_quiet_a: assert property (dacc_valid && !dacc_write |=> !vec_abort)
    else $error("vector read aborted");
  addr_exc_cause_a: assert property (addr_exc |-> $past(dacc_valid) && !$past(program_space_width_select) &&
    !$past(data_space_width_select) && $past(dacc_addr[31:26]) != 6'h00) else $error("address exception without cause");
  addr_exc_fire_a: assert property (dacc_valid && !program_space_width_select && !data_space_width_select && dacc_addr[31:26] != 6'h00 &&
    !exc_req |=> addr_exc) else $error("address exception missing");
  addr_exc_entry_a: assert property (addr_exc |-> status_word[4:0] == 5'h03 && status_word[7] &&
    pc == 32'h14 && link_data == $past(dacc_insn_addr) + 32'h4) else $error("address entry");
endmodule // pms_ctrl_chk
bind pms_ctrl pms_ctrl_chk u_chk (
  .ref_clk(ref_clk), .rst(rst),
  .exc_req(exc_req), .bx_req(bx_req), .pc_step(pc_step), .pc_we(pc_we), .sw_req(sw_req),
  .restore_req(restore_req), .dacc_valid(dacc_valid), .dacc_write(dacc_write), .exc_kind(exc_kind),
  .exc_addr(exc_addr), .bx_target(bx_target), .dacc_addr(dacc_addr), .dacc_insn_addr(dacc_insn_addr),
  .status_word(status_word), .saved_word(saved_word), .pc(pc), .r15_value(r15_value),
  .link_data(link_data), .compact(compact), .program_space_width_select(program_space_width_select), .data_space_width_select(data_space_width_select),
  .addr_exc(addr_exc), .vec_abort(vec_abort)
);

// ---- pms_defs.vh ----
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define PMS_M_USR26      5'h00
`define PMS_M_FIQ26      5'h01
`define PMS_M_IRQ26      5'h02
`define PMS_M_SVC26      5'h03
`define PMS_M_USR32      5'h10
`define PMS_M_FIQ32      5'h11
`define PMS_M_IRQ32      5'h12
`define PMS_M_SVC32      5'h13
`define PMS_M_ABT32      5'h17
`define PMS_M_UND32      5'h1B
`define PMS_M_SYS32      5'h1F
// ----------------------------------------
// Status word fields and reset values
// ----------------------------------------
`define PMS_M4_BIT       4
`define PMS_T_BIT        5
`define PMS_F_BIT        6
`define PMS_I_BIT        7
`define PMS_SW_RST       32'h000000D3
`define PMS_CTRL_PROG    0
`define PMS_CTRL_DATA    1
`define PMS_CTRL_RST     2'h3
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMS_OFS_CTRL     8'h04
`define PMS_OFS_STATUS   8'h08
`define PMS_OFS_SAVED    8'h0C
`define PMS_OFS_LINK     8'h10
`define PMS_OFS_PC       8'h14
// ----------------------------------------
// Exception kinds, vector is kind times four
// ----------------------------------------
`define PMS_X_RESET      3'h0
`define PMS_X_UNDEF      3'h1
`define PMS_X_SWI        3'h2
`define PMS_X_PABT       3'h3
`define PMS_X_DABT       3'h4
`define PMS_X_ADDR       3'h5
`define PMS_X_IRQ        3'h6
`define PMS_X_FIQ        3'h7
`define PMS_SWK_MSR      1'h0
`define PMS_SWK_PSR_WRITE_COMPARE     1'h1
// ----------------------------------------
// Address and offset constants
// ----------------------------------------
`define PMS_HARD_VEC_TOP 32'h0000001F
`define PMS_PC26_MASK    32'h03FFFFFC
`define PMS_PC26_KEEP    32'h03FFFFFF
`define PMS_PLUS2        32'h00000002
`define PMS_PLUS4        32'h00000004
`define PMS_PLUS8        32'h00000008
`define PMS_HAS_26BIT    1'b1
`define PMS_HAS_SYS      1'b1
`define PMS_VEC_RD_ABORT 1'b0
`endif

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "pms_defs.vh"
module tb_top;
  reg         ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  reg  [7:0]  avs_address = 8'h00;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hF;
  reg         exc_req = 1'b0, sw_req = 1'b0, sw_kind = 1'b0, restore_req = 1'b0, bx_req = 1'b0;
  reg         pc_we = 1'b0, pc_step = 1'b0, dacc_valid = 1'b0, dacc_write = 1'b0;
  reg  [2:0]  exc_kind = 3'h0;
  reg  [31:0] exc_addr = 32'h0, sw_data = 32'h0, restore_pc = 32'h0, bx_target = 32'h0;
  reg  [31:0] pc_wdata = 32'h0, dacc_addr = 32'h0, dacc_insn_addr = 32'h0, rd;
  wire [31:0] avs_readdata, status_word, saved_word, pc, r15_value, link_data, vec_addr, daddr_out;
  wire        avs_waitrequest, has_saved, compact, hi_bank_fiq, program_space_width_select, data_space_width_select;
  wire        link_we, vec_valid, addr_exc, vec_abort;
  wire [2:0]  sp_lr_bank, link_bank;
  integer     errors = 0, n_compared = 0, cyc = 0, i;
  // Kinds undef..fiq other than address, with expected modes, link offsets and banks
  localparam [17:0] KT = {3'h7, 3'h6, 3'h4, 3'h3, 3'h2, 3'h1};
  localparam [29:0] MT = {5'h11, 5'h12, 5'h17, 5'h17, 5'h13, 5'h1B};
  localparam [23:0] OC = {4'h4, 4'h4, 4'h8, 4'h4, 4'h2, 4'h2};
  localparam [23:0] OF = {4'h4, 4'h4, 4'h8, 4'h4, 4'h4, 4'h4};
  localparam [17:0] BK = {3'h1, 3'h2, 3'h4, 3'h4, 3'h3, 3'h5};
  always #20 ref_clk = ~ref_clk;
  pms_ctrl DUT (
    .ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .exc_req(exc_req), .exc_kind(exc_kind), .exc_addr(exc_addr), .sw_req(sw_req), .sw_kind(sw_kind),
    .sw_data(sw_data), .restore_req(restore_req), .restore_pc(restore_pc), .bx_req(bx_req),
    .bx_target(bx_target), .pc_we(pc_we), .pc_wdata(pc_wdata), .pc_step(pc_step),
    .dacc_valid(dacc_valid), .dacc_write(dacc_write), .dacc_addr(dacc_addr), .dacc_insn_addr(dacc_insn_addr),
    .status_word(status_word), .saved_word(saved_word), .has_saved(has_saved), .pc(pc),
    .r15_value(r15_value), .compact(compact), .hi_bank_fiq(hi_bank_fiq), .sp_lr_bank(sp_lr_bank),
    .program_space_width_select(program_space_width_select), .data_space_width_select(data_space_width_select), .link_we(link_we), .link_bank(link_bank), .link_data(link_data),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .addr_exc(addr_exc), .vec_abort(vec_abort),
    .daddr_out(daddr_out)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task give_verdict; begin
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      give_verdict;
    end
  end
  task chk(input [95:0] got, input [95:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  // Request held until waitrequest is sampled low
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q); begin
    @(posedge ref_clk);
    avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= ~w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
    #1;
  end endtask
  // One-cycle pulses; results are checked in the cycle after
  task fire; begin
    @(posedge ref_clk);
    exc_req <= 1'b0; sw_req <= 1'b0; restore_req <= 1'b0; bx_req <= 1'b0;
    pc_we <= 1'b0; pc_step <= 1'b0; dacc_valid <= 1'b0;
    #1;
  end endtask
  task exc(input [2:0] k, input [31:0] a); begin
    @(posedge ref_clk); exc_req <= 1'b1; exc_kind <= k; exc_addr <= a; fire;
  end endtask
  task sw(input k, input [31:0] d); begin
    @(posedge ref_clk); sw_req <= 1'b1; sw_kind <= k; sw_data <= d; fire;
  end endtask
  task bx(input [31:0] t); begin
    @(posedge ref_clk); bx_req <= 1'b1; bx_target <= t; fire;
  end endtask
  task dac(input w, input [31:0] a); begin
    @(posedge ref_clk); dacc_valid <= 1'b1; dacc_write <= w; dacc_addr <= a; dacc_insn_addr <= 32'h400; fire;
  end endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(status_word, `PMS_SW_RST);
    chk({program_space_width_select, data_space_width_select}, 32'h3);
    chk(r15_value, 32'h8);
    bus(1'b0, `PMS_OFS_CTRL, 32'h0, rd); chk(rd, 32'h3);
    bus(1'b0, 8'h00, 32'h0, rd); chk(rd, 32'h0);
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      bx(32'h1001); chk(compact, 1'b1);
      exc(KT[i*3 +: 3], 32'h2000); chk(link_data, 32'h2000 + OC[i*4 +: 4]);
      chk({compact, saved_word[5], status_word[4:0]}, {2'h1, MT[i*5 +: 5]});
      chk({link_we, link_bank, vec_valid, vec_addr}, {1'b1, BK[i*3 +: 3], 1'b1, 27'h0, KT[i*3 +: 3], 2'h0});
      bx(32'h1000); exc(KT[i*3 +: 3], 32'h2000); chk(link_data, 32'h2000 + OF[i*4 +: 4]);
    end
    exc(`PMS_X_RESET, 32'h0); chk({link_we, status_word[7:0], vec_addr}, {1'b0, 8'hD3, 32'h0});
    $display("test exception links done");
    bx(32'h1001); @(posedge ref_clk); pc_step <= 1'b1; fire; @(posedge ref_clk); #1;
    chk(pc, 32'h1002); chk(r15_value, 32'h1006);
    @(posedge ref_clk); pc_we <= 1'b1; pc_wdata <= 32'h2003; fire; chk(pc, 32'h2002);
    exc(`PMS_X_UNDEF, 32'h2002); chk(link_data, 32'h2004);
    @(posedge ref_clk); restore_req <= 1'b1; restore_pc <= 32'h2004; fire;
    chk({compact, pc}, {1'b1, 32'h2004});
    bx(32'h1000); @(posedge ref_clk); pc_step <= 1'b1; fire; chk(pc, 32'h1004);
    $display("test compact state done");
    sw(`PMS_SWK_MSR, 32'hDF); chk({status_word[4:0], has_saved}, {5'h1F, 1'b0});
    sw(`PMS_SWK_MSR, 32'hD1); chk({hi_bank_fiq, sp_lr_bank}, 4'h9);
    sw(`PMS_SWK_MSR, 32'hC3); chk(status_word[4:0], 5'h03);
    dac(1'b1, 32'h10); chk(vec_abort, 1'b1);
    dac(1'b0, 32'h10); chk(vec_abort, 1'b0);
    dac(1'b1, 32'h20); chk(vec_abort, 1'b0);
    sw(`PMS_SWK_PSR_WRITE_COMPARE, 32'hC2); chk(status_word[4:0], 5'h02);
    exc(`PMS_X_SWI, 32'hFC000100); chk(link_data, 32'h104);
    chk({saved_word & 32'hF0000003, status_word[4:0]}, {32'h2, 5'h13});
    $display("test 26-bit modes done");
    bus(1'b1, `PMS_OFS_CTRL, 32'h0, rd); chk(program_space_width_select, 1'b0);
    exc(`PMS_X_DABT, 32'h80); chk(status_word[4:0], 5'h03);
    sw(`PMS_SWK_MSR, 32'hD2); chk(status_word[4:0], 5'h02);
    dac(1'b0, 32'h04000000); chk(addr_exc, 1'b1);
    chk({status_word[7], status_word[4:0], pc, link_data}, {6'h23, 32'h14, 32'h404});
    chk({vec_valid, vec_addr, link_bank}, {1'b1, 32'h14, 3'h3});
    dac(1'b0, 32'h03FFFFFF); chk({addr_exc, link_we, vec_valid}, 3'h0);
    @(posedge ref_clk); pc_we <= 1'b1; pc_wdata <= 32'hFC001000; fire; chk(pc, 32'h1000);
    bus(1'b1, `PMS_OFS_CTRL, 32'h2, rd);
    dac(1'b0, 32'h80000000); chk({addr_exc, daddr_out}, {1'b0, 32'h80000000});
    bus(1'b0, `PMS_OFS_CTRL, 32'h0, rd); chk(rd, 32'h2);
    $display("test 26-bit configuration done");
    give_verdict;
  end
endmodule // tb_top
